// ### logic/cdgc_pkg.sv
// Purpose: shared constants and carriers for the processor domain gate control
// Assumes: word index times four gives the byte address on the bus
// Notes:   gate bit positions match both staging and status layouts
package cdgc_pkg;
  // register word indices
  localparam logic [7:0]  STAGE_IDX    = 8'h01;
  localparam logic [7:0]  STATUS_IDX   = 8'h02;
  localparam logic [7:0]  IRQ_STAT_IDX = 8'h03;
  localparam logic [7:0]  IRQ_MASK_IDX = 8'h04;
  // gate bit positions
  localparam int ACCEL_BIT = 9;
  localparam int FETCH_BIT = 8;
  localparam int MEM_BIT   = 7;
  localparam int IO_BIT    = 6;
  localparam int DATA_BIT  = 5;
  localparam int CFG_MSB   = 4;
  localparam int CFG_LSB   = 1;
  localparam int CORE_BIT  = 0;
  // field values and masks
  localparam logic [3:0]  CFG_LEGAL    = 4'h7;
  localparam logic [15:0] STAGE_MASK   = 16'h03ff;
  localparam logic [15:0] STATUS_MASK  = 16'h03e1;
  localparam logic [15:0] WAKE_CLR     = 16'h0161;
  localparam logic [15:0] STAGE_RST    = 16'h0000;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  // interrupt status bits
  localparam int IRQ_APPLIED = 0;
  localparam int IRQ_FAULT   = 1;
  localparam int IRQ_WAKE    = 2;
  localparam int IRQ_W       = 3;
  localparam logic [2:0]  IRQ_RST      = 3'h0;
  // wake flag delay line stages, in core cycles; the flag shows one cycle after the last stage
  localparam int WAKE_LAT_CYC = 3;

  // ahb-lite request side
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } cdgc_ahb_req_t;

  // ahb-lite answer side
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } cdgc_ahb_rsp_t;

  // per-part gate enables, one means clock stopped
  typedef struct packed {
    logic accel;
    logic fetch;
    logic mem;
    logic io;
    logic data;
    logic core;
  } cdgc_gates_t;
endpackage

// ### logic/cdgc_top.sv
// Purpose: processor domain clock gate control with staged config
// Assumes: sleep strobe is a one-cycle pulse on the core clock
// Notes:   wake and emulator inputs are pins and get synchronised
// Behaviour
// R1: sleep copies staging into status
// R2: gates driven from status, not staging
// R3: bit 9 gates fft accelerator
// R4: bit 8 gates fetch port
// R5: bit 7 gates on-chip memory port
// R6: bit 6 gates io-space port
// R7: bit 5 gates data port
// R8: bit 0 gates the core
// R9: software writes field 4..1 as 0111
// R10: status shows gated parts at six bits
// R11: port gates need field 0111, else fault
// R12: data, io, fetch gates need core gate
// R13: software idles dma before memory port gate
// R14: attached emulator overrides gating
// R15: wake clears core, data, io, fetch bits
// R16: flag visible three cycles after wake; code raises it four cycles after the wake level
// R17: accelerator and memory port ignore wake
// R18: gated core halts execution
// R19: staging keeps value after sleep
`timescale 1ns/1ns
module cdgc_top #(
  parameter int LAT = cdgc_pkg::WAKE_LAT_CYC
) (
  // clock and reset
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_I,
  // register bus
  input  wire cdgc_pkg::cdgc_ahb_req_t AHB_I,
  output      cdgc_pkg::cdgc_ahb_rsp_t AHB_O,
  // core side
  input  wire logic                    SLEEP_EXEC_I,
  input  wire logic                    WAKE_IRQ_I,
  input  wire logic                    EMU_ATTACHED_I,
  // gating and events
  output      cdgc_pkg::cdgc_gates_t   GATE_O,
  output      logic                    HALT_O,
  output      logic                    BUS_FAULT_O,
  output      logic                    IRQ_VISIBLE_O,
  output      logic                    IRQ_O
);
  import cdgc_pkg::*;

  // elaboration check
  // pipe indexing needs at least two stages
  if (LAT < 2 || LAT > 8) begin : g_lat_chk
    $error("LAT must be 2 to 8");
  end
  // wake sample to visible flag sample, in assertion cycles
  localparam int VIS_DLY = LAT + 1;

  logic [15:0]      stage_reg, stage_next;
  logic [15:0]      status_reg, status_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [2:0]       wake_sync_reg;
  logic [2:0]       emu_sync_reg;
  logic             wake_lvl_reg;
  logic             emu_lvl_reg;
  logic [LAT-1:0]   vis_pipe_reg;
  logic             vis_reg;
  logic             wr_pend_reg;
  logic [7:0]       wr_idx_reg;
  cdgc_ahb_rsp_t    rsp_reg, rsp_next;
  cdgc_gates_t      gate_reg, gate_next;
  logic             halt_reg;
  logic             fault_reg;
  logic             irq_reg;

  // legality of a staged configuration
  // R12: data, io and fetch port gates need core
  function automatic logic cfg_legal(input logic [15:0] c);
    logic port_any;
    logic need_core;
    port_any  = c[DATA_BIT] | c[IO_BIT] | c[FETCH_BIT] | c[MEM_BIT];
    need_core = c[DATA_BIT] | c[IO_BIT] | c[FETCH_BIT];
    cfg_legal = !(port_any && (c[CFG_MSB:CFG_LSB] != CFG_LEGAL)) &&
                !(need_core && !c[CORE_BIT]);
  endfunction

  // bus address phase decode
  wire        bus_go   = AHB_I.hsel & AHB_I.htrans[1] & AHB_I.hready;
  wire        bus_rd   = bus_go & ~AHB_I.hwrite;
  wire        bus_wr   = bus_go & AHB_I.hwrite;
  wire [7:0]  addr_idx = AHB_I.haddr[9:2];
  wire        wr_stage = wr_pend_reg && (wr_idx_reg == STAGE_IDX);
  wire        wr_istat = wr_pend_reg && (wr_idx_reg == IRQ_STAT_IDX);
  wire        wr_imask = wr_pend_reg && (wr_idx_reg == IRQ_MASK_IDX);
  wire [15:0] wdata16  = AHB_I.hwdata[15:0];

  // read data selection, unmapped reads zero
  // R10: status readable by software
  logic [31:0] rd_word;
  always_comb begin
    if (addr_idx == STAGE_IDX) begin
      rd_word = {16'h0000, stage_reg};
    end else if (addr_idx == STATUS_IDX) begin
      rd_word = {16'h0000, status_reg};
    end else if (addr_idx == IRQ_STAT_IDX) begin
      rd_word = {29'h0000000, irq_stat_reg};
    end else if (addr_idx == IRQ_MASK_IDX) begin
      rd_word = {29'h0000000, irq_mask_reg};
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // sleep outcome
  wire sleep_ok  = SLEEP_EXEC_I & cfg_legal(stage_reg);
  // R11: rejected sleep faults
  wire sleep_bad = SLEEP_EXEC_I & ~cfg_legal(stage_reg);
  // R16: core woken by interrupt
  wire core_woke = wake_lvl_reg & status_reg[CORE_BIT] & ~sleep_ok;

  // R19: staging written only by software
  assign stage_next = wr_stage ? (wdata16 & STAGE_MASK) : stage_reg;

  // R1: sleep copies staged config
  // R15: wake clears core and cpu ports
  // R17: accel and mem bits kept on wake
  always_comb begin
    if (sleep_ok) begin
      status_next = stage_reg & STATUS_MASK;
    end else if (wake_lvl_reg) begin
      status_next = status_reg & ~WAKE_CLR;
    end else begin
      status_next = status_reg;
    end
  end

  // sticky events, set beats clear
  wire [IRQ_W-1:0] irq_set = {core_woke, sleep_bad, sleep_ok};
  assign irq_stat_next = wr_istat ? ((irq_stat_reg & ~wdata16[IRQ_W-1:0]) | irq_set)
                                  : (irq_stat_reg | irq_set);
  assign irq_mask_next = wr_imask ? wdata16[IRQ_W-1:0] : irq_mask_reg;

  // R2: gates from status only
  // R3 R4 R5 R6 R7 R8: one bit per part
  // R14: emulator holds all parts clocked
  assign gate_next = emu_lvl_reg ? 6'h00 :
                     {status_reg[ACCEL_BIT], status_reg[FETCH_BIT],
                      status_reg[MEM_BIT], status_reg[IO_BIT],
                      status_reg[DATA_BIT], status_reg[CORE_BIT]};

  // bus answer, zero wait, always okay
  assign rsp_next = '{hrdata: (bus_rd ? rd_word : 32'h00000000),
                      hreadyout: 1'b1, hresp: 1'b0};

  // configuration and status registers
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stage_reg  <= STAGE_RST;
      status_reg <= STATUS_RST;
    end else begin
      stage_reg  <= stage_next;
      status_reg <= status_next;
    end
  end

  // interrupt status and mask
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // pin synchronisers, level moves when stages two and three agree
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      wake_sync_reg <= 3'h0;
      emu_sync_reg  <= 3'h0;
      wake_lvl_reg  <= 1'b0;
      emu_lvl_reg   <= 1'b0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], WAKE_IRQ_I};
      emu_sync_reg  <= {emu_sync_reg[1:0], EMU_ATTACHED_I};
      if (wake_sync_reg[1] == wake_sync_reg[2]) begin
        wake_lvl_reg <= wake_sync_reg[2];
      end
      if (emu_sync_reg[1] == emu_sync_reg[2]) begin
        emu_lvl_reg <= emu_sync_reg[2];
      end
    end
  end

  // R16: delay line to flag visibility
  // R18: halt follows core gate
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      vis_pipe_reg <= '0;
      vis_reg      <= 1'b0;
      gate_reg     <= 6'h00;
      halt_reg     <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      vis_pipe_reg <= {vis_pipe_reg[LAT-2:0], core_woke};
      vis_reg      <= vis_pipe_reg[LAT-1];
      gate_reg     <= gate_next;
      halt_reg     <= gate_next.core;
      fault_reg    <= sleep_bad;
    end
  end

  // bus data phase tracking
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rsp_reg     <= '{hrdata: 32'h00000000, hreadyout: 1'b1, hresp: 1'b0};
    end else begin
      wr_pend_reg <= bus_wr;
      wr_idx_reg  <= addr_idx;
      rsp_reg     <= rsp_next;
    end
  end

  // outputs straight from flops
  assign AHB_O         = rsp_reg;
  assign GATE_O        = gate_reg;
  assign HALT_O        = halt_reg;
  assign BUS_FAULT_O   = fault_reg;
  assign IRQ_VISIBLE_O = vis_reg;
  assign IRQ_O         = irq_reg;

  // checks on the core clock
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_wake;
    core_woke;
  endsequence
  sequence s_visible;
    ##VIS_DLY IRQ_VISIBLE_O;
  endsequence

  a_sleep_copy: assert property ( // R1
    sleep_ok |=> status_reg == ($past(stage_reg) & STATUS_MASK))
    else $error("status not loaded on sleep");
  a_gate_follow: assert property ( // R2
    !emu_lvl_reg && !$stable(status_reg) |=> !$stable(gate_reg) || emu_lvl_reg)
    else $error("gates ignore status");
  a_accel_gate: assert property ( // R3
    sleep_ok && stage_reg[ACCEL_BIT] && !emu_lvl_reg ##1 !emu_lvl_reg |=> GATE_O.accel)
    else $error("accelerator not gated");
  a_fetch_gate: assert property ( // R4
    sleep_ok && !stage_reg[FETCH_BIT] |=> !status_reg[FETCH_BIT])
    else $error("fetch gate wrong");
  a_mem_gate: assert property ( // R5
    sleep_ok |=> status_reg[MEM_BIT] == $past(stage_reg[MEM_BIT]))
    else $error("memory port gate wrong");
  a_io_gate: assert property ( // R6
    !emu_lvl_reg |=> GATE_O.io == $past(status_reg[IO_BIT]) || $past(emu_lvl_reg))
    else $error("io port gate wrong");
  a_data_gate: assert property ( // R7
    !emu_lvl_reg |=> GATE_O.data == $past(status_reg[DATA_BIT]) || $past(emu_lvl_reg))
    else $error("data port gate wrong");
  a_core_follow: assert property ( // R8
    !emu_lvl_reg |=> GATE_O.core == $past(status_reg[CORE_BIT]) || $past(emu_lvl_reg))
    else $error("core gate wrong");
  a_core_gate: assert property ( // R18
    GATE_O.core |-> HALT_O)
    else $error("core gate and halt differ");
  a_status_rsvd: assert property ( // R10
    (status_reg & ~STATUS_MASK) == 16'h0000)
    else $error("reserved status bits set");
  a_cfg_fault: assert property ( // R11
    SLEEP_EXEC_I && stage_reg[MEM_BIT] && stage_reg[4:1] != CFG_LEGAL
      |=> BUS_FAULT_O && ((status_reg | WAKE_CLR) == ($past(status_reg) | WAKE_CLR)))
    else $error("bad field not faulted");
  a_fault_only: assert property ( // R11
    !sleep_bad |=> !BUS_FAULT_O)
    else $error("fault without rejected sleep");
  a_core_need: assert property ( // R12
    SLEEP_EXEC_I && !stage_reg[CORE_BIT] &&
    (stage_reg[IO_BIT] || stage_reg[DATA_BIT] || stage_reg[FETCH_BIT])
      |=> BUS_FAULT_O && irq_stat_reg[IRQ_FAULT])
    else $error("missing core gate not faulted");
  a_emu_hold: assert property ( // R14
    emu_lvl_reg |=> GATE_O == 6'h00)
    else $error("gating while emulator attached");
  a_wake_clr: assert property ( // R15
    wake_lvl_reg && !sleep_ok |=> (status_reg & WAKE_CLR) == 16'h0000)
    else $error("wake did not clear bits");
  a_wake_vis: assert property ( // R16
    s_wake |-> s_visible)
    else $error("flag visibility latency wrong");
  a_vis_source: assert property ( // R16
    IRQ_VISIBLE_O |-> $past(core_woke, VIS_DLY))
    else $error("flag without wake");
  a_wake_keep: assert property ( // R17
    !sleep_ok |=> status_reg[ACCEL_BIT] == $past(status_reg[ACCEL_BIT]) &&
                  status_reg[MEM_BIT] == $past(status_reg[MEM_BIT]))
    else $error("accel or mem changed without sleep");
  a_stage_keep: assert property ( // R19
    !wr_stage |=> $stable(stage_reg))
    else $error("staging changed without write");
endmodule // cdgc_top

// ### verification/cdgc_core_model.sv
// Purpose: behavioural core that issues sleep and wake requests
// Assumes: one clock shared with the gate control
// Notes:   a halted core cannot execute a sleep
`timescale 1ns/1ns
module cdgc_core_model (
  // clock and core state
  input  wire logic clk_i,
  input  wire logic halt_i,
  // requests to the gate control
  output      logic sleep_o,
  output      logic wake_o
);
  // idle at time zero
  initial begin
    sleep_o = 1'b0;
    wake_o  = 1'b0;
  end
  // caller stages field 0111 and idles dma first
  task automatic go_sleep();
    if (halt_i !== 1'b1) begin
      sleep_o <= 1'b1;
      @(posedge clk_i);
      sleep_o <= 1'b0;
    end
    @(posedge clk_i);
  endtask
  // level interrupt held long enough to pass the synchroniser
  task automatic go_wake();
    wake_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    wake_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // cdgc_core_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the processor domain gate control
// Assumes: zero or more wait states, single word transfers
// Notes:   outputs are sampled mid-cycle to stay clear of edge races
`timescale 1ns/1ns
module tb_top;
  import cdgc_pkg::*;
  localparam int LAT = 3;
  localparam logic [15:0] CFG_TAB [10] = '{16'h0200, 16'h0001, 16'h008e, 16'h0080,
    16'h0021, 16'h002e, 16'h004f, 16'h010f, 16'h002f, 16'h03ef};
  logic          clk;
  logic          rst;
  logic          emu;
  logic          sleep;
  logic          wake;
  cdgc_ahb_req_t ahb_q;
  cdgc_ahb_req_t ahb_w;
  cdgc_ahb_rsp_t rsp;
  cdgc_gates_t   gates;
  logic          halt;
  logic          fault;
  logic          vis;
  logic          irq;
  logic [31:0]   rd_s;
  logic          rdy_s;
  logic          irq_s;
  logic          halt_q = 1'b0;
  logic [6:0]    obs_s;
  logic [15:0]   st;
  int            n_mismatch = 0;
  int            checks_done = 0;
  int            cyc = 0;
  int            n_fault = 0;
  int            n_vis = 0;
  int            fall_c = 0;

  cdgc_top #(.LAT(LAT)) u_cdgc_top (.CORE_CLK_I(clk), .RST_I(rst), .AHB_I(ahb_w),
    .AHB_O(rsp), .SLEEP_EXEC_I(sleep), .WAKE_IRQ_I(wake), .EMU_ATTACHED_I(emu),
    .GATE_O(gates), .HALT_O(halt), .BUS_FAULT_O(fault), .IRQ_VISIBLE_O(vis), .IRQ_O(irq));
  cdgc_core_model u_cdgc_core_model (.clk_i(clk), .halt_i(halt), .sleep_o(sleep),
    .wake_o(wake));

  // single slave, so hready is its hreadyout
  always_comb begin
    ahb_w        = ahb_q;
    ahb_w.hready = rsp.hreadyout;
  end
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog and cycle count
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // mid-cycle samples of settled outputs
  always @(negedge clk) begin
    rd_s  = rsp.hrdata;
    rdy_s = rsp.hreadyout;
    irq_s = irq;
    obs_s = {gates, halt};
    if (fault === 1'b1) n_fault++;
    if (halt_q === 1'b1 && halt === 1'b0) fall_c = cyc;
    halt_q = halt;
    if (vis === 1'b1) begin
      n_vis++;
      cmp(32'(cyc - fall_c), 32'(LAT - 1));
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one ahb-lite single transfer, read data left in rd_s
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    ahb_q.hsel   <= 1'b1;
    ahb_q.htrans <= 2'h2;
    ahb_q.haddr  <= {22'h0, idx, 2'h0};
    ahb_q.hwrite <= w;
    ahb_q.hsize  <= 3'h2;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
    ahb_q.hsel   <= 1'b0;
    ahb_q.htrans <= 2'h0;
    ahb_q.hwdata <= wd;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    cmp(rd_s, exp);
  endtask
  function automatic logic ok(input logic [15:0] c);
    return !((|c[8:5]) && c[4:1] != CFG_LEGAL) && !((|{c[8], c[6], c[5]}) && !c[0]);
  endfunction
  function automatic logic [31:0] gexp(input logic [15:0] s);
    return {25'h0, s[9], s[8], s[7], s[6], s[5], s[0], s[0]};
  endfunction
  // main sequence
  initial begin
    int f0;
    int v0;
    rst    = 1'b1;
    emu    = 1'b0;
    ahb_q  = '0;
    st     = 16'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 1; i < 5; i++) rchk(8'(i), 32'h0);
    rchk(8'h20, 32'h0);
    bus(1'b1, STATUS_IDX, 32'hffff);
    rchk(STATUS_IDX, 32'h0);
    bus(1'b1, STAGE_IDX, 32'hffff);
    rchk(STAGE_IDX, {16'h0, STAGE_MASK});
    // each gate bit, legal and faulting sleeps
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, STAGE_IDX, {16'h0, CFG_TAB[i]});
      f0 = n_fault;
      u_cdgc_core_model.go_sleep();
      if (ok(CFG_TAB[i])) st = CFG_TAB[i] & STATUS_MASK;
      repeat (2) @(posedge clk);
      rchk(STATUS_IDX, {16'h0, st});
      cmp(32'(n_fault - f0), {31'h0, !ok(CFG_TAB[i])});
      cmp({25'h0, obs_s}, gexp(st));
      rchk(STAGE_IDX, {16'h0, CFG_TAB[i]});
      if (st[0]) begin
        v0 = n_vis;
        u_cdgc_core_model.go_wake();
        st = st & ~WAKE_CLR;
        rchk(STATUS_IDX, {16'h0, st});
        cmp(32'(n_vis - v0), 32'h1);
      end
    end
    // interrupt raised, masked, cleared
    cmp({31'h0, irq_s}, 32'h0);
    bus(1'b1, IRQ_MASK_IDX, 32'h7);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq_s}, 32'h1);
    rchk(IRQ_STAT_IDX, 32'h7);
    bus(1'b1, IRQ_STAT_IDX, 32'h7);
    rchk(IRQ_STAT_IDX, 32'h0);
    cmp({31'h0, irq_s}, 32'h0);
    bus(1'b1, IRQ_MASK_IDX, 32'h2);
    bus(1'b1, STAGE_IDX, 32'h0);
    u_cdgc_core_model.go_sleep();
    repeat (3) @(posedge clk);
    cmp({31'h0, irq_s}, 32'h0);
    rchk(IRQ_STAT_IDX, 32'h1);
    // attached emulator keeps clocks running
    emu <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b1, STAGE_IDX, 32'h03ef);
    u_cdgc_core_model.go_sleep();
    repeat (2) @(posedge clk);
    rchk(STATUS_IDX, 32'h03e1);
    cmp({25'h0, obs_s}, 32'h0);
    emu <= 1'b0;
    repeat (6) @(posedge clk);
    cmp({25'h0, obs_s}, gexp(16'h03e1));
    test_done();
  end
endmodule // tb_top
